// >>> hdl/umd_pkg.sv
package umd_pkg;

	// ****************************************************************
	// register map (byte addresses, one aligned word each)
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_RXDATA = 8'h08;
	localparam logic [7:0] OFS_SLAVE_ADDR = 8'h0c;
	localparam logic [7:0] OFS_SLAVE_MASK = 8'h10;

	// ****************************************************************
	// control register fields
	// ****************************************************************
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MD_EN = 2;
	localparam int CTRL_RX_EN = 3;
	localparam int CTRL_TX_NINTH = 4;
	localparam int CTRL_FCHK = 5;
	localparam int CTRL_SIRQ_EN = 6;
	localparam int CTRL_GIRQ_EN = 7;

	// ****************************************************************
	// status register fields
	// ****************************************************************
	localparam int STAT_RXC = 0;
	localparam int STAT_TXC = 1;
	localparam int STAT_RX_NINTH = 2;
	localparam int STAT_FERR = 3;

	// ****************************************************************
	// modes, frame layout, reset values, bus answers
	// ****************************************************************
	localparam logic [1:0] MODE_SYNC = 2'h0;
	localparam logic [1:0] MODE_ASYNC8 = 2'h1;
	localparam logic [3:0] IDX_LAST_SYNC = 4'h7;
	localparam logic [3:0] IDX_STOP8 = 4'h9;
	localparam logic [3:0] IDX_NINTH = 4'h9;
	localparam logic [3:0] IDX_STOP9 = 4'ha;
	localparam logic [7:0] RST_SLAVE_ADDR = 8'h00;
	localparam logic [7:0] RST_SLAVE_MASK = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {
		UMD_RX_IDLE,
		UMD_RX_SHIFT
	} umd_rx_phase_e;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [7:0] wdata;
		logic wstrb0;
		logic [1:0] mode;
		logic md_en;
		logic rx_en;
		logic tx_ninth;
		logic fchk;
		logic sirq_en;
		logic girq_en;
		logic rxc;
		logic txc;
		logic rx_ninth;
		logic ferr;
		logic [7:0] rxdata;
		logic [7:0] slave_addr;
		logic [7:0] slave_mask;
		umd_rx_phase_e phase;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic ninth_tmp;
		logic irq;
	} umd_state_s;

endpackage : umd_pkg

// >>> hdl/umd_match_if.sv
interface umd_match_if;
	logic [7:0] slave_addr;
	logic [7:0] slave_mask;
	logic [7:0] rx_byte;
	logic match;

	modport core (output slave_addr, output slave_mask, output rx_byte, input match);
	modport filter (input slave_addr, input slave_mask, input rx_byte, output match);
endinterface : umd_match_if

// >>> hdl/umd_addr_filter.sv
module umd_addr_filter (
	umd_match_if.filter mif
);

	// ****************************************************************
	// masked comparison: zero bits of the care mask are ignored
	// ****************************************************************
	function automatic logic masked_eq(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] care);
		masked_eq = ((a ^ b) & care) == 8'h00;
	endfunction : masked_eq

	logic [7:0] bcast;
	logic hit_given;
	logic hit_bcast;

	always_comb begin
		bcast = mif.slave_addr | mif.slave_mask;
		hit_given = masked_eq(mif.rx_byte, mif.slave_addr, mif.slave_mask);
		hit_bcast = masked_eq(mif.rx_byte, bcast, bcast);
		mif.match = hit_given | hit_bcast;
	end

endmodule : umd_addr_filter

// >>> hdl/umd_address_filter.sv
// Function
// - with multidrop in 9-bit modes, ninth bit one means address, zero data
// - with multidrop, ninth-bit-zero frames set neither complete nor ninth flag
// - matching address frame sets received ninth bit and receive complete
// - 8-bit mode: stop bit acts as ninth; needs match and valid stop
// - synchronous mode ignores multidrop enable completely
// - individual address: slave address with mask zeros as don't-care
// - broadcast address is address OR mask, zeros don't-care
// - a frame matches on individual or broadcast address
// - reset clears slave address and mask to zero, everything matches
// - receive and transmit complete are ORed into one interrupt
// - interrupt reaches core only with serial and global enables set
// - receive complete rises at last data bit, ninth bit or stop bit per mode and framing check
// - 9-bit frame: start, eight data bits lsb first, ninth, stop
// - 8-bit frame is ten bits; stop bit lands in received ninth bit
// - with framing check, receive complete rises at the stop bit
module umd_address_filter #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_bit_strobe,
	input wire logic rx_bit,
	input wire logic tx_done,
	output logic tx_ninth_bit,
	output logic serial_irq
);

	umd_pkg::umd_state_s st_ff;
	umd_pkg::umd_state_s nxt_st;
	umd_match_if mif ();

	umd_addr_filter u_filter (
		.mif(mif.filter)
	);

	// ****************************************************************
	// frame delivery: the decision point of the receiver
	// ****************************************************************
	logic deliver;
	logic [7:0] dlv_byte;
	logic dlv_ninth;
	logic md_active;
	logic accept;
	logic do_write;
	logic [7:0] wofs;
	logic wr_stat;

	assign mif.slave_addr = st_ff.slave_addr;
	assign mif.slave_mask = st_ff.slave_mask;
	assign mif.rx_byte = dlv_byte;

	always_comb begin
		nxt_st = st_ff;
		deliver = 1'b0;
		dlv_byte = st_ff.shift;
		dlv_ninth = st_ff.rx_ninth;
		// synchronous mode never filters
		md_active = st_ff.md_en && (st_ff.mode != umd_pkg::MODE_SYNC);
		do_write = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
		wofs = st_ff.awaddr;
		wr_stat = do_write && st_ff.wstrb0 && (wofs == umd_pkg::OFS_STATUS);

		// ************************************************************
		// write channel
		// ************************************************************
		if (s_axi_awvalid && st_ff.awready) begin
			nxt_st.awaddr = 8'(s_axi_awaddr);
			nxt_st.aw_got = 1'b1;
			nxt_st.awready = 1'b0;
		end
		if (s_axi_wvalid && st_ff.wready) begin
			nxt_st.wdata = s_axi_wdata[7:0];
			nxt_st.wstrb0 = s_axi_wstrb[0];
			nxt_st.w_got = 1'b1;
			nxt_st.wready = 1'b0;
		end
		if (do_write) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = umd_pkg::RESP_OKAY;
			case (wofs)
				umd_pkg::OFS_CTRL: begin
					if (st_ff.wstrb0) begin
						nxt_st.mode = st_ff.wdata[umd_pkg::CTRL_MODE_LSB +: 2];
						nxt_st.md_en = st_ff.wdata[umd_pkg::CTRL_MD_EN];
						nxt_st.rx_en = st_ff.wdata[umd_pkg::CTRL_RX_EN];
						nxt_st.tx_ninth = st_ff.wdata[umd_pkg::CTRL_TX_NINTH];
						nxt_st.fchk = st_ff.wdata[umd_pkg::CTRL_FCHK];
						nxt_st.sirq_en = st_ff.wdata[umd_pkg::CTRL_SIRQ_EN];
						nxt_st.girq_en = st_ff.wdata[umd_pkg::CTRL_GIRQ_EN];
					end
				end
				umd_pkg::OFS_STATUS: begin
					// write-one-to-clear, applied below before hardware sets
				end
				umd_pkg::OFS_RXDATA: begin
					// read-only, write ignored
				end
				umd_pkg::OFS_SLAVE_ADDR: begin
					if (st_ff.wstrb0) begin
						nxt_st.slave_addr = st_ff.wdata;
					end
				end
				umd_pkg::OFS_SLAVE_MASK: begin
					if (st_ff.wstrb0) begin
						nxt_st.slave_mask = st_ff.wdata;
					end
				end
				default: begin
					nxt_st.bresp = umd_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
			nxt_st.awready = 1'b1;
			nxt_st.wready = 1'b1;
		end

		// complete and error flags are cleared only by software
		if (wr_stat) begin
			nxt_st.rxc = st_ff.rxc & ~st_ff.wdata[umd_pkg::STAT_RXC];
			nxt_st.txc = st_ff.txc & ~st_ff.wdata[umd_pkg::STAT_TXC];
			nxt_st.ferr = st_ff.ferr & ~st_ff.wdata[umd_pkg::STAT_FERR];
		end

		// ************************************************************
		// read channel
		// ************************************************************
		if (s_axi_arvalid && st_ff.arready) begin
			nxt_st.arready = 1'b0;
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = umd_pkg::RESP_OKAY;
			nxt_st.rdata = 32'h0000_0000;
			case (8'(s_axi_araddr))
				umd_pkg::OFS_CTRL: begin
					nxt_st.rdata[7:0] = {st_ff.girq_en, st_ff.sirq_en, st_ff.fchk,
						st_ff.tx_ninth, st_ff.rx_en, st_ff.md_en, st_ff.mode};
				end
				umd_pkg::OFS_STATUS: begin
					nxt_st.rdata[3:0] = {st_ff.ferr, st_ff.rx_ninth, st_ff.txc, st_ff.rxc};
				end
				umd_pkg::OFS_RXDATA: begin
					nxt_st.rdata[7:0] = st_ff.rxdata;
				end
				umd_pkg::OFS_SLAVE_ADDR: begin
					nxt_st.rdata[7:0] = st_ff.slave_addr;
				end
				umd_pkg::OFS_SLAVE_MASK: begin
					nxt_st.rdata[7:0] = st_ff.slave_mask;
				end
				default: begin
					nxt_st.rresp = umd_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
			nxt_st.arready = 1'b1;
		end

		// ************************************************************
		// receive sequencer, one step per sampled bit
		// ************************************************************
		if (rx_bit_strobe) begin
			case (st_ff.phase)
				umd_pkg::UMD_RX_IDLE: begin
					if (st_ff.rx_en && st_ff.mode == umd_pkg::MODE_SYNC) begin
						nxt_st.shift = {rx_bit, st_ff.shift[7:1]};
						nxt_st.cnt = 4'h1;
						nxt_st.phase = umd_pkg::UMD_RX_SHIFT;
					end else if (st_ff.rx_en && !rx_bit) begin
						// start bit seen
						nxt_st.cnt = 4'h1;
						nxt_st.phase = umd_pkg::UMD_RX_SHIFT;
					end
				end
				umd_pkg::UMD_RX_SHIFT: begin
					nxt_st.cnt = st_ff.cnt + 4'h1;
					if (st_ff.mode == umd_pkg::MODE_SYNC) begin
						nxt_st.shift = {rx_bit, st_ff.shift[7:1]};
						if (st_ff.cnt == umd_pkg::IDX_LAST_SYNC) begin
							deliver = 1'b1;
							dlv_byte = {rx_bit, st_ff.shift[7:1]};
							nxt_st.phase = umd_pkg::UMD_RX_IDLE;
						end
					end else if (st_ff.cnt < umd_pkg::IDX_NINTH) begin
						nxt_st.shift = {rx_bit, st_ff.shift[7:1]};
					end else if (st_ff.mode == umd_pkg::MODE_ASYNC8) begin
						// ten-bit frame ends here; stop bit doubles as ninth
						deliver = 1'b1;
						dlv_ninth = rx_bit;
						nxt_st.phase = umd_pkg::UMD_RX_IDLE;
						if (st_ff.fchk && !rx_bit) begin
							nxt_st.ferr = 1'b1;
						end
					end else if (st_ff.cnt == umd_pkg::IDX_NINTH) begin
						nxt_st.ninth_tmp = rx_bit;
						if (!st_ff.fchk) begin
							// stop bit still pending, so a bad stop goes unseen here
							deliver = 1'b1;
							dlv_ninth = rx_bit;
						end
					end else begin
						nxt_st.phase = umd_pkg::UMD_RX_IDLE;
						if (st_ff.fchk) begin
							deliver = 1'b1;
							dlv_ninth = st_ff.ninth_tmp;
							if (!rx_bit) begin
								nxt_st.ferr = 1'b1;
							end
						end
					end
				end
				default: begin
					nxt_st.phase = umd_pkg::UMD_RX_IDLE;
				end
			endcase
		end

		// acceptance decision, hardware sets win over software clears
		if (!md_active) begin
			accept = 1'b1;
		end else begin
			accept = dlv_ninth && mif.match;
		end
		if (deliver && accept) begin
			nxt_st.rxdata = dlv_byte;
			nxt_st.rxc = 1'b1;
			if (st_ff.mode != umd_pkg::MODE_SYNC) begin
				nxt_st.rx_ninth = dlv_ninth;
			end
		end
		if (tx_done) begin
			nxt_st.txc = 1'b1;
		end
		nxt_st.irq = (nxt_st.rxc | nxt_st.txc) & nxt_st.sirq_en & nxt_st.girq_en;

		if (!aresetn) begin
			nxt_st = '0;
			nxt_st.awready = 1'b1;
			nxt_st.wready = 1'b1;
			nxt_st.arready = 1'b1;
			nxt_st.phase = umd_pkg::UMD_RX_IDLE;
			nxt_st.slave_addr = umd_pkg::RST_SLAVE_ADDR;
			nxt_st.slave_mask = umd_pkg::RST_SLAVE_MASK;
		end
	end

	always_ff @(posedge aclk) begin
		st_ff <= nxt_st;
	end

	assign s_axi_awready = st_ff.awready;
	assign s_axi_wready = st_ff.wready;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = st_ff.arready;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rresp = st_ff.rresp;
	assign s_axi_rdata = st_ff.rdata;
	assign tx_ninth_bit = st_ff.tx_ninth;
	assign serial_irq = st_ff.irq;

	// ****************************************************************
	// checks
	// ****************************************************************
	sequence s_ninth9;
		rx_bit_strobe && st_ff.phase == umd_pkg::UMD_RX_SHIFT && st_ff.mode[1]
			&& st_ff.cnt == umd_pkg::IDX_NINTH;
	endsequence

	sequence s_md_frame;
		deliver && md_active;
	endsequence

	property p_irq_gate;
		@(posedge aclk) disable iff (!aresetn)
		serial_irq |-> st_ff.sirq_en && st_ff.girq_en;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");

	property p_irq_src;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff.rxc || st_ff.txc) && st_ff.sirq_en && st_ff.girq_en |-> serial_irq;
	endproperty
	a_irq_src: assert property (p_irq_src) else $error("flag not merged into irq");

	property p_data_drop;
		@(posedge aclk) disable iff (!aresetn)
		s_md_frame and (st_ff.mode[1] && !dlv_ninth) |=> !$rose(st_ff.rxc);
	endproperty
	a_data_drop: assert property (p_data_drop) else $error("data frame not dropped");

	property p_addr_hit;
		@(posedge aclk) disable iff (!aresetn)
		s_md_frame and (st_ff.mode[1] && dlv_ninth && mif.match)
			|=> st_ff.rxc && st_ff.rx_ninth;
	endproperty
	a_addr_hit: assert property (p_addr_hit) else $error("address hit not flagged");

	property p_stop_addr;
		@(posedge aclk) disable iff (!aresetn)
		s_md_frame and (st_ff.mode == umd_pkg::MODE_ASYNC8 && !(dlv_ninth && mif.match))
			|=> !$rose(st_ff.rxc);
	endproperty
	a_stop_addr: assert property (p_stop_addr) else $error("8-bit address check failed");

	property p_plain_rx;
		@(posedge aclk) disable iff (!aresetn)
		deliver && !md_active |=> st_ff.rxc && st_ff.rxdata == $past(dlv_byte);
	endproperty
	a_plain_rx: assert property (p_plain_rx) else $error("plain frame lost");

	property p_miss_keep;
		@(posedge aclk) disable iff (!aresetn)
		s_md_frame and !mif.match |=> $stable(st_ff.rxdata) && !$rose(st_ff.rxc);
	endproperty
	a_miss_keep: assert property (p_miss_keep) else $error("miss changed receiver");

	property p_fchk_stop;
		@(posedge aclk) disable iff (!aresetn)
		s_ninth9 and st_ff.fchk |=> !$rose(st_ff.rxc);
	endproperty
	a_fchk_stop: assert property (p_fchk_stop) else $error("flag rose before stop");

	property p_reset_addr;
		@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |-> st_ff.slave_addr == 8'h00 && st_ff.slave_mask == 8'h00;
	endproperty
	a_reset_addr: assert property (p_reset_addr) else $error("address regs not cleared");

endmodule : umd_address_filter

// >>> verif/umd_peer.sv
module umd_peer (
	input wire logic aclk,
	output logic rx_bit_strobe,
	output logic rx_bit
);
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************************************
	// idle line
	// ****************************************************************
	initial begin
		rx_bit_strobe = 1'b0;
		rx_bit = 1'b1;
	end

	// ****************************************************************
	// frame sender
	// ****************************************************************
	// kind 0 sync, 1 eight-bit, 2 nine-bit, 3 a lone bit; nb cuts a frame short
	// gap 0 gives back-to-back strobes, larger gaps a slow sender
	task automatic send(input logic [7:0] b, input logic n9, input logic stp,
		input int kind, input int nb, input int gap);
		logic [10:0] f;
		int len;
		f = (kind == 0) ? {3'h0, b} : {stp, n9, b, 1'b0};
		if (kind == 1) f[9] = stp;
		if (kind == 3) f = {10'h0, stp};
		len = (kind == 0) ? 8 : (kind == 1) ? 10 : (kind == 2) ? 11 : 1;
		if (nb < len) len = nb;
		for (int i = 0; i < len; i++) begin
			@(posedge aclk);
			rx_bit_strobe <= 1'b1;
			rx_bit <= f[i];
			if (gap > 0) begin
				@(posedge aclk);
				rx_bit_strobe <= 1'b0;
				// between strobes the line shows the inverse, never the held bit
				rx_bit <= ~f[i];
				repeat (gap - 1) @(posedge aclk);
			end
		end
		@(posedge aclk);
		rx_bit_strobe <= 1'b0;
		rx_bit <= 1'b1;
	endtask : send
endmodule : umd_peer

// >>> verif/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected at %0t: got %h exp %h", $time, g, e); end end
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h0;
	logic [7:0] araddr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic tx_done = 1'b0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, strobe, sbit, tx_ninth_bit, serial_irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [35:0] exp_q[$];
	logic [35:0] note;
	logic e_txn = 1'b0;
	logic e_irq = 1'b0;
	logic e_n9 = 1'b0;
	logic [7:0] e_dat = 8'h0;
	logic [7:0] b;
	int seed = 8;
	int error_cnt = 0;
	int tests_run = 0;

	always #10 aclk = ~aclk;

	umd_address_filter dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_bit_strobe(strobe),
		.rx_bit(sbit), .tx_done(tx_done), .tx_ninth_bit(tx_ninth_bit),
		.serial_irq(serial_irq)
	);

	umd_peer u_peer (.aclk(aclk), .rx_bit_strobe(strobe), .rx_bit(sbit));

	// ****************************************************************
	// result watcher
	// ****************************************************************
	always @(posedge aclk) begin
		if (bvalid && bready) begin
			note = exp_q.pop_front();
			`CHK(bresp, note[33:32])
		end
		if (rvalid && rready) begin
			note = exp_q.pop_front();
			`CHK({tx_ninth_bit, serial_irq, rresp, rdata}, note)
		end
	end

	// ****************************************************************
	// bus and frame tasks
	// ****************************************************************
	task automatic end_of_test;
		if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_of_test

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		exp_q.push_back({2'b00, r, 32'h0});
		@(posedge aclk);
		awaddr <= a;
		// upper bits are ignored by the design, so they carry noise
		wdata <= (32'($random(seed)) & 32'hffffff00) | d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid && bready) && n < 40);
		bready <= 1'b0;
		if (n >= 40) begin
			error_cnt++;
			end_of_test();
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		exp_q.push_back({e_txn, e_irq, r, d});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid && rready) && n < 40);
		rready <= 1'b0;
		if (n >= 40) begin
			error_cnt++;
			end_of_test();
		end
	endtask : rd

	task automatic cfg(input logic [1:0] m, input logic md, input logic fc, input logic [1:0] ie);
		wr(umd_pkg::OFS_CTRL, {24'h0, ie, fc, e_txn, 1'b1, md, m}, umd_pkg::RESP_OKAY);
	endtask : cfg

	function automatic logic hit(input logic [7:0] v, input logic [7:0] a, input logic [7:0] m);
		hit = (((v ^ a) & m) == 8'h0) || (((v ^ (a | m)) & (a | m)) == 8'h0);
	endfunction : hit

	// one frame, then status and data are read and the flag is cleared
	task automatic rx(input logic [7:0] v, input logic n9, input logic stp, input int kind,
		input int nb, input logic acc);
		u_peer.send(v, n9, stp, kind, nb, {$random(seed)} % 3);
		repeat (2) @(posedge aclk);
		if (acc) begin
			e_dat = v;
			if (kind != 0) e_n9 = (kind == 1) ? stp : n9;
		end
		rd(umd_pkg::OFS_STATUS, {29'h0, e_n9, 1'b0, acc}, umd_pkg::RESP_OKAY);
		rd(umd_pkg::OFS_RXDATA, {24'h0, e_dat}, umd_pkg::RESP_OKAY);
		wr(umd_pkg::OFS_STATUS, 32'h1, umd_pkg::RESP_OKAY);
	endtask : rx

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(umd_pkg::OFS_SLAVE_ADDR, 32'(umd_pkg::RST_SLAVE_ADDR), umd_pkg::RESP_OKAY);
		rd(umd_pkg::OFS_SLAVE_MASK, 32'(umd_pkg::RST_SLAVE_MASK), umd_pkg::RESP_OKAY);
		rd(8'h14, 32'h0, umd_pkg::RESP_SLVERR);
		wr(8'h14, 32'h5a, umd_pkg::RESP_SLVERR);
		cfg(2'h3, 1'b1, 1'b0, 2'h0);
		rx(8'h5a, 1'b1, 1'b1, 2, 11, 1'b1);
		rx(8'h33, 1'b0, 1'b1, 2, 11, 1'b0);
		wr(umd_pkg::OFS_SLAVE_ADDR, 32'h56, umd_pkg::RESP_OKAY);
		wr(umd_pkg::OFS_SLAVE_MASK, 32'hfc, umd_pkg::RESP_OKAY);
		for (int i = 0; i < 14; i++) begin
			if (i == 7) cfg(2'h2, 1'b1, 1'b0, 2'h0);
			b = (i % 7 < 5) ? 8'h55 + 8'(i % 7) * 8'h29 : 8'(i * 37);
			rx(b, 1'b1, 1'b1, 2, 11, hit(b, 8'h56, 8'hfc));
		end
		rx(8'hff, 1'b1, 1'b1, 2, 11, 1'b1);
		wr(umd_pkg::OFS_SLAVE_ADDR, 32'ha5, umd_pkg::RESP_OKAY);
		wr(umd_pkg::OFS_SLAVE_MASK, 32'hff, umd_pkg::RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			b = (i == 0) ? 8'ha5 : (i == 1) ? 8'ha4 : 8'($random(seed));
			rx(b, 1'b1, 1'b1, 2, 11, hit(b, 8'ha5, 8'hff));
		end
		// a write without the low byte lane must leave the register alone
		wstrb <= 4'he;
		wr(umd_pkg::OFS_SLAVE_ADDR, 32'h3c, umd_pkg::RESP_OKAY);
		wstrb <= 4'hf;
		rd(umd_pkg::OFS_SLAVE_ADDR, 32'ha5, umd_pkg::RESP_OKAY);
		cfg(2'h3, 1'b0, 1'b0, 2'h0);
		rx(8'h11, 1'b0, 1'b1, 2, 11, 1'b1);
		rx(8'h12, 1'b1, 1'b1, 2, 11, 1'b1);
		e_txn = 1'b1;
		cfg(2'h1, 1'b1, 1'b0, 2'h0);
		rx(8'ha5, 1'b0, 1'b1, 1, 11, 1'b1);
		rx(8'ha5, 1'b0, 1'b0, 1, 11, 1'b0);
		rx(8'h3c, 1'b0, 1'b1, 1, 11, 1'b0);
		cfg(2'h0, 1'b1, 1'b0, 2'h0);
		rx(8'h3c, 1'b0, 1'b1, 0, 11, 1'b1);
		cfg(2'h3, 1'b1, 1'b0, 2'h0);
		rx(8'ha5, 1'b1, 1'b1, 2, 10, 1'b1);
		u_peer.send(8'h0, 1'b0, 1'b1, 3, 1, 0);
		cfg(2'h3, 1'b1, 1'b1, 2'h0);
		rx(8'ha5, 1'b1, 1'b1, 2, 10, 1'b0);
		rx(8'ha5, 1'b1, 1'b1, 3, 1, 1'b1);
		// bad stop with framing check: error flag set, frame still taken
		u_peer.send(8'ha5, 1'b1, 1'b0, 2, 11, 1);
		repeat (2) @(posedge aclk);
		rd(umd_pkg::OFS_STATUS, {28'h0, 4'hd}, umd_pkg::RESP_OKAY);
		wr(umd_pkg::OFS_STATUS, 32'h9, umd_pkg::RESP_OKAY);
		cfg(2'h3, 1'b0, 1'b0, 2'h1);
		@(posedge aclk);
		tx_done <= 1'b1;
		@(posedge aclk);
		tx_done <= 1'b0;
		rd(umd_pkg::OFS_STATUS, {29'h0, e_n9, 2'b10}, umd_pkg::RESP_OKAY);
		cfg(2'h3, 1'b0, 1'b0, 2'h2);
		rd(umd_pkg::OFS_STATUS, {29'h0, e_n9, 2'b10}, umd_pkg::RESP_OKAY);
		cfg(2'h3, 1'b0, 1'b0, 2'h3);
		e_irq = 1'b1;
		rd(umd_pkg::OFS_STATUS, {29'h0, e_n9, 2'b10}, umd_pkg::RESP_OKAY);
		wr(umd_pkg::OFS_STATUS, 32'h2, umd_pkg::RESP_OKAY);
		e_irq = 1'b0;
		rd(umd_pkg::OFS_STATUS, {29'h0, e_n9, 2'b00}, umd_pkg::RESP_OKAY);
		e_irq = 1'b1;
		rx(8'h77, 1'b0, 1'b1, 2, 11, 1'b1);
		e_irq = 1'b0;
		rd(umd_pkg::OFS_STATUS, {29'h0, e_n9, 2'b00}, umd_pkg::RESP_OKAY);
		// receiver disabled: a whole frame must pass unseen
		wr(umd_pkg::OFS_CTRL, {24'h0, 2'h0, 1'b0, e_txn, 1'b0, 1'b0, 2'h3}, umd_pkg::RESP_OKAY);
		rx(8'h44, 1'b1, 1'b1, 2, 11, 1'b0);
		end_of_test();
	end
endmodule : tb
